// *** verilog/cabi_pkg.sv ***
// How it works
// - Upper strobe qualifies bits 15..8, lower bits 7..0; direction high reads.
// - Single-byte writes carry the same byte on both data lanes.
// - Acknowledge is registered internally; sampled in S4, read data captured in S6.
// - Fault together with acknowledge wins and aborts the cycle.
// - Grant output announces release of the bus after the current cycle.
// - Class codes 1,2,5,6,7 as listed; 0,3,4 reserved.
// - Class lines stay valid for the whole address strobe.
// - Fault ends the cycle; with halt it retries, otherwise raises an exception.
// - Reset request drives the open-drain reset line, internal state untouched.
// - External halt and reset together start full system initialisation.
// - External halt stops after the current cycle, controls negated, buses floated.
// - A self-stop (double fault) drives the halt line.
// - Buses float on halt or grant taken; control lines float only on grant taken.
// - Enable clock from a ring counter, ten clocks: six low, four high.
// - Slow select synchronises to the enable clock; in interrupt ack it autovectors.
// - Slow address valid asserts only in answer to slow select.
// - Recognised acknowledge latches data and ends a read; ends a write.
// - Interrupt ack puts level on address bits 3..1, bits 23..4 high.
// - Byte access: select bit 0 uses upper strobe, 1 uses lower strobe.
package cabi_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;

    localparam int unsigned ECLK_PERIOD = 10;
    localparam int unsigned ECLK_LOW = 6;
    localparam logic [9:0] ECLK_RING_RESET = 10'h001;

    localparam int unsigned RESET_DRIVE_CYCLES = 124;

    localparam logic [2:0] CLASS_USER_DATA = 3'h1;
    localparam logic [2:0] CLASS_USER_PROG = 3'h2;
    localparam logic [2:0] CLASS_SUPV_DATA = 3'h5;
    localparam logic [2:0] CLASS_SUPV_PROG = 3'h6;
    localparam logic [2:0] CLASS_IRQ_ACK = 3'h7;
    localparam logic [2:0] CLASS_IDLE = 3'h0;

    localparam logic [19:0] IACK_ADDR_HIGH = 20'hFFFFF;

    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [22:0] ADDR_RESET = 23'h000000;

    // Gray along IDLE, S0, S2, S4, S6, S7; SLOW and HALT sit off the path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_S0 = 3'h1,
        ST_S2 = 3'h3,
        ST_S4 = 3'h2,
        ST_S6 = 3'h6,
        ST_S7 = 3'h7,
        ST_SLOW = 3'h5,
        ST_HALT = 3'h4
    } cabi_state_t;

endpackage

// *** verilog/cabi_eclk_if.sv ***
`timescale 1ns/1ps
interface cabi_eclk_if;
    logic level;
    logic low_start;
    logic last;
    modport src (output level, output low_start, output last);
    modport snk (input level, input low_start, input last);
endinterface

// *** verilog/cabi_eclk_gen.sv ***
`timescale 1ns/1ps
module cabi_eclk_gen
    import cabi_pkg::*;
#(
    parameter int unsigned PERIOD = ECLK_PERIOD,
    parameter int unsigned LOW = ECLK_LOW
) (
    input wire logic clk,
    input wire logic rst,
    cabi_eclk_if.src e
);
    logic [PERIOD-1:0] ring_r;

    // One-hot ring; bit 0 is the first low clock, bits LOW.. are high
    always_ff @(posedge clk) begin
        if (rst) begin
            ring_r <= PERIOD'(ECLK_RING_RESET);
        end else begin
            ring_r <= {ring_r[PERIOD-2:0], ring_r[PERIOD-1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            e.level <= 1'b0;
            e.low_start <= 1'b0;
            e.last <= 1'b0;
        end else begin
            e.level <= |ring_r[PERIOD-2:LOW-1];
            e.low_start <= ring_r[PERIOD-1];
            e.last <= ring_r[PERIOD-2];
        end
    end
endmodule

// *** verilog/cabi_top.sv ***
`timescale 1ns/1ps
module cabi_top
    import cabi_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_DRIVE_CYCLES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CORE_REQ,
    input wire logic CORE_READ,
    input wire logic CORE_BYTE,
    input wire logic [23:0] CORE_ADDR,
    input wire logic [15:0] CORE_WDATA,
    input wire logic [2:0] CORE_CLASS,
    input wire logic CORE_RESET_EXT,
    input wire logic CORE_STOPPED,
    output logic CORE_READY,
    output logic CORE_DONE,
    output logic CORE_FAULT,
    output logic CORE_AUTOVEC,
    output logic [15:0] CORE_RDATA,
    output logic CORE_HALTED,
    output logic CORE_SYS_INIT,
    output logic [2:0] CORE_IRQ_LEVEL,
    output logic [22:0] ADDR_OUT,
    output logic ADDR_OE,
    input wire logic [15:0] DATA_IN,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE,
    output logic ADDR_STROBE_N,
    output logic DIR_READ,
    output logic UPPER_LANE_STROBE_N,
    output logic LOWER_LANE_STROBE_N,
    output logic [2:0] CYCLE_CLASS,
    output logic SLOW_ADDR_VALID_N,
    output logic CTRL_OE,
    input wire logic TRANSFER_ACK_N,
    input wire logic BUS_FAULT_IN_N,
    input wire logic MASTERSHIP_REQUEST_N,
    output logic MASTERSHIP_GRANT_N,
    input wire logic GRANT_TAKEN_N,
    input wire logic [2:0] IRQ_LEVEL_N,
    input wire logic SLOW_PERIPH_SELECT_N,
    output logic ENABLE_CLK,
    input wire logic RESET_LINE_IN_N,
    output logic RESET_LINE_OUT,
    output logic RESET_LINE_OE,
    input wire logic HALT_LINE_IN_N,
    output logic HALT_LINE_OUT,
    output logic HALT_LINE_OE
);
    cabi_state_t state_r;
    logic ack_s_r;
    logic fault_s_r;
    logic periph_s_r;
    logic req_s_r;
    logic taken_s_r;
    logic halt_ext_r;
    logic rst_ext_r;
    logic pend_r;
    logic retry_r;
    logic fault_hit_r;
    logic rd_r;
    logic byte_r;
    logic [23:0] addr_r;
    logic [15:0] wdata_r;
    logic [2:0] class_r;
    logic [1:0] lanes_r;
    logic [7:0] rst_cnt_r;
    logic [7:0] rst_cnt_nxt;

    cabi_eclk_if eclk ();

    cabi_eclk_gen #(
        .PERIOD(ECLK_PERIOD),
        .LOW(ECLK_LOW)
    ) u_eclk (
        .clk(CLK),
        .rst(SYS_RST),
        .e(eclk.src)
    );

    assign ENABLE_CLK = eclk.level;

    // Active-low lane enables {upper, lower} for the access size
    function automatic logic [1:0] lane_strobes(input logic is_byte, input logic sel);
        if (!is_byte) begin
            lane_strobes = 2'h0;
        end else if (sel) begin
            lane_strobes = 2'h2;
        end else begin
            lane_strobes = 2'h1;
        end
    endfunction

    // Registered view of the asynchronous pins
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ack_s_r <= 1'b0;
            fault_s_r <= 1'b0;
            periph_s_r <= 1'b0;
            req_s_r <= 1'b0;
            taken_s_r <= 1'b0;
            halt_ext_r <= 1'b0;
            rst_ext_r <= 1'b0;
            CORE_IRQ_LEVEL <= 3'h0;
        end else begin
            ack_s_r <= ~TRANSFER_ACK_N;
            fault_s_r <= ~BUS_FAULT_IN_N;
            periph_s_r <= ~SLOW_PERIPH_SELECT_N;
            req_s_r <= ~MASTERSHIP_REQUEST_N;
            taken_s_r <= ~GRANT_TAKEN_N;
            halt_ext_r <= ~HALT_LINE_IN_N & ~HALT_LINE_OE;
            rst_ext_r <= ~RESET_LINE_IN_N & ~RESET_LINE_OE;
            CORE_IRQ_LEVEL <= ~IRQ_LEVEL_N;
        end
    end

    // Grant only when no cycle is about to raise the strobe
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MASTERSHIP_GRANT_N <= 1'b1;
        end else if (taken_s_r || !req_s_r) begin
            MASTERSHIP_GRANT_N <= 1'b1;
        end else if (state_r != ST_S0) begin
            MASTERSHIP_GRANT_N <= 1'b0;
        end
    end

    // Open-drain reset and halt lines
    always_comb begin
        rst_cnt_nxt = rst_cnt_r;
        if (CORE_RESET_EXT) begin
            rst_cnt_nxt = 8'(RESET_CYCLES);
        end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_nxt = rst_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rst_cnt_r <= 8'h00;
            RESET_LINE_OE <= 1'b0;
            RESET_LINE_OUT <= 1'b0;
            HALT_LINE_OE <= 1'b0;
            HALT_LINE_OUT <= 1'b0;
            CORE_SYS_INIT <= 1'b0;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            RESET_LINE_OE <= rst_cnt_nxt != 8'h00;
            RESET_LINE_OUT <= 1'b0;
            HALT_LINE_OE <= CORE_STOPPED;
            HALT_LINE_OUT <= 1'b0;
            CORE_SYS_INIT <= rst_ext_r & halt_ext_r;
        end
    end

    // Bus cycle sequencer
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= ST_IDLE;
            pend_r <= 1'b0;
            retry_r <= 1'b0;
            fault_hit_r <= 1'b0;
            rd_r <= 1'b1;
            byte_r <= 1'b0;
            addr_r <= 24'h000000;
            wdata_r <= DATA_RESET;
            class_r <= CLASS_IDLE;
            lanes_r <= 2'h3;
            CORE_READY <= 1'b1;
            CORE_DONE <= 1'b0;
            CORE_FAULT <= 1'b0;
            CORE_AUTOVEC <= 1'b0;
            CORE_RDATA <= DATA_RESET;
            ADDR_OUT <= ADDR_RESET;
            DATA_OUT <= DATA_RESET;
            DATA_OE <= 1'b0;
            ADDR_STROBE_N <= 1'b1;
            DIR_READ <= 1'b1;
            UPPER_LANE_STROBE_N <= 1'b1;
            LOWER_LANE_STROBE_N <= 1'b1;
            CYCLE_CLASS <= CLASS_IDLE;
            SLOW_ADDR_VALID_N <= 1'b1;
        end else begin
            CORE_DONE <= 1'b0;
            CORE_FAULT <= 1'b0;
            if (CORE_REQ && CORE_READY) begin
                pend_r <= 1'b1;
                CORE_READY <= 1'b0;
                rd_r <= CORE_READ;
                byte_r <= CORE_BYTE;
                addr_r <= CORE_ADDR;
                wdata_r <= CORE_WDATA;
                class_r <= CORE_CLASS;
                lanes_r <= lane_strobes(CORE_BYTE, CORE_ADDR[0]);
            end
            unique case (state_r)
                ST_IDLE: begin
                    if (halt_ext_r) begin
                        state_r <= ST_HALT;
                    end else if (pend_r && MASTERSHIP_GRANT_N && !taken_s_r) begin
                        state_r <= ST_S0;
                        retry_r <= 1'b0;
                        CORE_AUTOVEC <= 1'b0;
                        DIR_READ <= rd_r;
                        CYCLE_CLASS <= class_r;
                        if (class_r == CLASS_IRQ_ACK) begin
                            ADDR_OUT <= {IACK_ADDR_HIGH, addr_r[3:1]};
                        end else begin
                            ADDR_OUT <= addr_r[23:1];
                        end
                    end
                end
                ST_S0: begin
                    state_r <= ST_S2;
                    ADDR_STROBE_N <= 1'b0;
                    if (rd_r) begin
                        UPPER_LANE_STROBE_N <= lanes_r[1];
                        LOWER_LANE_STROBE_N <= lanes_r[0];
                    end else begin
                        DATA_OE <= 1'b1;
                        if (byte_r) begin
                            DATA_OUT <= {wdata_r[7:0], wdata_r[7:0]};
                        end else begin
                            DATA_OUT <= wdata_r;
                        end
                    end
                end
                ST_S2: begin
                    state_r <= ST_S4;
                    UPPER_LANE_STROBE_N <= lanes_r[1];
                    LOWER_LANE_STROBE_N <= lanes_r[0];
                end
                ST_S4: begin
                    if (fault_s_r) begin
                        state_r <= ST_S7;
                        fault_hit_r <= 1'b1;
                        retry_r <= halt_ext_r;
                    end else if (ack_s_r) begin
                        state_r <= ST_S6;
                    end else if (periph_s_r) begin
                        state_r <= ST_SLOW;
                        CORE_AUTOVEC <= class_r == CLASS_IRQ_ACK;
                    end
                end
                ST_S6: begin
                    state_r <= ST_S7;
                    if (rd_r) begin
                        CORE_RDATA <= DATA_IN;
                    end
                end
                ST_SLOW: begin
                    if (fault_s_r) begin
                        state_r <= ST_S7;
                        fault_hit_r <= 1'b1;
                        retry_r <= halt_ext_r;
                        SLOW_ADDR_VALID_N <= 1'b1;
                    end else if (SLOW_ADDR_VALID_N && eclk.low_start) begin
                        SLOW_ADDR_VALID_N <= 1'b0;
                    end else if (!SLOW_ADDR_VALID_N && eclk.last) begin
                        state_r <= ST_S7;
                        SLOW_ADDR_VALID_N <= 1'b1;
                        if (rd_r && !CORE_AUTOVEC) begin
                            CORE_RDATA <= DATA_IN;
                        end
                    end
                end
                ST_S7: begin
                    ADDR_STROBE_N <= 1'b1;
                    UPPER_LANE_STROBE_N <= 1'b1;
                    LOWER_LANE_STROBE_N <= 1'b1;
                    DATA_OE <= 1'b0;
                    CYCLE_CLASS <= CLASS_IDLE;
                    fault_hit_r <= 1'b0;
                    if (retry_r) begin
                        state_r <= ST_HALT;
                    end else begin
                        state_r <= ST_IDLE;
                        pend_r <= 1'b0;
                        CORE_READY <= 1'b1;
                        CORE_DONE <= !fault_hit_r;
                        CORE_FAULT <= fault_hit_r;
                    end
                end
                ST_HALT: begin
                    if (!halt_ext_r) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Three-state enables; control lines float only while another master holds the bus
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ADDR_OE <= 1'b0;
            CTRL_OE <= 1'b0;
            CORE_HALTED <= 1'b0;
        end else begin
            ADDR_OE <= !taken_s_r && state_r != ST_HALT;
            CTRL_OE <= !taken_s_r;
            CORE_HALTED <= state_r == ST_HALT;
        end
    end


endmodule

// *** bench/cabi_top_props.sv ***
`timescale 1ns/1ps
module cabi_top_props
    import cabi_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic ADDR_STROBE_N,
    input wire logic [2:0] CYCLE_CLASS,
    input wire logic DATA_OE,
    input wire logic [15:0] DATA_OUT,
    input wire logic DIR_READ,
    input wire logic UPPER_LANE_STROBE_N,
    input wire logic LOWER_LANE_STROBE_N,
    input wire logic ENABLE_CLK,
    input wire logic SLOW_ADDR_VALID_N,
    input wire logic BUS_FAULT_IN_N,
    input wire logic HALT_LINE_IN_N,
    input wire logic CORE_FAULT,
    input wire logic GRANT_TAKEN_N,
    input wire logic ADDR_OE,
    input wire logic CTRL_OE,
    input wire logic CORE_HALTED,
    input wire logic [22:0] ADDR_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_class_stable: assert property (!ADDR_STROBE_N && $past(!ADDR_STROBE_N) |-> $stable(CYCLE_CLASS))
        else $error("cycle class changed under address strobe");
    a_byte_mirror: assert property (DATA_OE && !DIR_READ && (UPPER_LANE_STROBE_N != LOWER_LANE_STROBE_N)
        |-> DATA_OUT[15:8] == DATA_OUT[7:0])
        else $error("byte write not mirrored");
    a_eclk_high: assert property ($rose(ENABLE_CLK) |-> ENABLE_CLK [*4] ##1 !ENABLE_CLK)
        else $error("enable clock high phase wrong");
    a_eclk_low: assert property ($fell(ENABLE_CLK) |-> !ENABLE_CLK [*6] ##1 ENABLE_CLK)
        else $error("enable clock low phase wrong");
    a_slow_sync: assert property ($fell(SLOW_ADDR_VALID_N) |-> !ADDR_STROBE_N && !ENABLE_CLK)
        else $error("slow address valid out of step");
    a_fault_end: assert property ($fell(BUS_FAULT_IN_N) && !ADDR_STROBE_N && HALT_LINE_IN_N
        |-> ##[1:12] CORE_FAULT)
        else $error("bus fault did not end cycle");
    a_grant_float: assert property (!GRANT_TAKEN_N [*3] |-> !ADDR_OE && !CTRL_OE && !DATA_OE)
        else $error("lines driven while grant taken");
    a_halt_float: assert property (CORE_HALTED |-> !ADDR_OE && !DATA_OE && ADDR_STROBE_N
        && UPPER_LANE_STROBE_N && LOWER_LANE_STROBE_N)
        else $error("lines active while halted");
    a_iack_addr: assert property (!ADDR_STROBE_N && CYCLE_CLASS == CLASS_IRQ_ACK
        |-> ADDR_OUT[22:3] == IACK_ADDR_HIGH)
        else $error("interrupt ack address high bits wrong");
endmodule

// *** bench/cabi_far_model.sv ***
`timescale 1ns/1ps
module cabi_far_model (
    input wire logic clk,
    input wire logic addr_strobe_n,
    input wire logic [22:0] addr,
    input wire logic [1:0] mode,
    input wire logic [3:0] delay,
    output logic ack_n,
    output logic fault_n,
    output logic slow_sel_n,
    output logic [15:0] data
);
    logic [3:0] cnt_r;
    logic [15:0] pat;

    assign pat = addr[15:0] ^ 16'hC3A5;

    // Modes: 0 ack, 1 fault, 2 fault with ack, 3 slow peripheral
    always_ff @(posedge clk) begin
        if (addr_strobe_n) begin
            cnt_r <= 4'h0;
            ack_n <= 1'b1;
            fault_n <= 1'b1;
            slow_sel_n <= 1'b1;
            data <= ~pat;
        end else if (cnt_r == delay && ack_n && fault_n && slow_sel_n) begin
            ack_n <= !(mode == 2'h0 || mode == 2'h2);
            fault_n <= !(mode == 2'h1 || mode == 2'h2);
            slow_sel_n <= !(mode == 2'h3);
            data <= pat;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            data <= (ack_n && fault_n && slow_sel_n) ? ~pat : pat;
        end
    end
endmodule

// *** bench/tb_cabi_top.sv ***
`timescale 1ns/1ps
module tb_cabi_top;
    import cabi_pkg::*;
    localparam int RST_CYC = 4;
    logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, rd = 1'b0, byt = 1'b0, rst_ext = 1'b0;
    logic stopped = 1'b0, mreq_n = 1'b1, gt_n = 1'b1, ext_halt = 1'b0, ext_rst = 1'b0;
    logic [23:0] addr = 24'h000000;
    logic [15:0] wdata = 16'h0000;
    logic [2:0] cls = 3'h1, irq_n = 3'h7;
    logic [1:0] mode = 2'h0;
    logic [3:0] dly = 4'h0;
    logic ready, done, fault, autovec, halted, sys_init, addr_oe, data_oe, as_n, dir_rd;
    logic us_n, ls_n, vma_n, ctrl_oe, ack_n, fault_n, grant_n, slow_n, eclk, rl_oe, hl_oe;
    logic [15:0] rdata, din, dout, sdo;
    logic [2:0] irq_lvl, cyc_cls, scls;
    logic [22:0] addr_out, sad;
    logic su, sl, sv, sd;
    wire halt_n = ~(ext_halt | hl_oe);
    wire reset_n = ~(ext_rst | rl_oe);
    int err_total = 0;
    int checked = 0;

    always #25 clk = ~clk;

    cabi_top #(.RESET_CYCLES(RST_CYC)) cabi_top_inst (.CLK(clk), .SYS_RST(sys_rst),
        .CORE_REQ(req), .CORE_READ(rd), .CORE_BYTE(byt), .CORE_ADDR(addr), .CORE_WDATA(wdata),
        .CORE_CLASS(cls), .CORE_RESET_EXT(rst_ext), .CORE_STOPPED(stopped), .CORE_READY(ready),
        .CORE_DONE(done), .CORE_FAULT(fault), .CORE_AUTOVEC(autovec), .CORE_RDATA(rdata),
        .CORE_HALTED(halted), .CORE_SYS_INIT(sys_init), .CORE_IRQ_LEVEL(irq_lvl),
        .ADDR_OUT(addr_out), .ADDR_OE(addr_oe), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE(data_oe), .ADDR_STROBE_N(as_n), .DIR_READ(dir_rd), .UPPER_LANE_STROBE_N(us_n),
        .LOWER_LANE_STROBE_N(ls_n), .CYCLE_CLASS(cyc_cls), .SLOW_ADDR_VALID_N(vma_n),
        .CTRL_OE(ctrl_oe), .TRANSFER_ACK_N(ack_n), .BUS_FAULT_IN_N(fault_n),
        .MASTERSHIP_REQUEST_N(mreq_n), .MASTERSHIP_GRANT_N(grant_n), .GRANT_TAKEN_N(gt_n),
        .IRQ_LEVEL_N(irq_n), .SLOW_PERIPH_SELECT_N(slow_n), .ENABLE_CLK(eclk),
        .RESET_LINE_IN_N(reset_n), .RESET_LINE_OUT(), .RESET_LINE_OE(rl_oe),
        .HALT_LINE_IN_N(halt_n), .HALT_LINE_OUT(), .HALT_LINE_OE(hl_oe));

    cabi_far_model cabi_far_model_inst (.clk(clk), .addr_strobe_n(as_n), .addr(addr_out),
        .mode(mode), .delay(dly), .ack_n(ack_n), .fault_n(fault_n), .slow_sel_n(slow_n),
        .data(din));

    task automatic summarize;
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge clk);
            #5;
        end
    endtask

    task automatic xfer(input logic r, input logic b, input logic [23:0] a, input logic [2:0] c,
        input logic [1:0] m);
        int i;
        rd = r; byt = b; addr = a; cls = c; mode = m; req = 1'b1;
        su = 1'b0; sl = 1'b0; sv = 1'b0;
        tick();
        req = 1'b0;
        for (i = 0; i < 80 && !(done || fault); i++) begin
            if (!as_n) begin
                scls = cyc_cls;
                sad = addr_out;
                sd = dir_rd;
            end
            su |= !us_n; sl |= !ls_n; sv |= !vma_n;
            if (data_oe && !(us_n && ls_n)) sdo = dout;
            tick();
        end
        bound(i, 80);
    endtask

    task automatic sc_word;
        for (int d = 0; d < 4; d += 3) begin
            dly = d[3:0];
            xfer(1'b1, 1'b0, 24'h00A4C2, CLASS_SUPV_DATA, 2'h0);
            chk(done && !fault && su && sl && sd === 1'b1 && ready, "word read end");
            chk(rdata === (addr[16:1] ^ 16'hC3A5), "read data");
            wdata = 16'hBEEF;
            xfer(1'b0, 1'b0, 24'h001000, CLASS_USER_DATA, 2'h0);
            chk(done && sdo === 16'hBEEF && su && sl && sd === 1'b0, "word write");
        end
        dly = 4'h0;
    endtask

    task automatic sc_bytes;
        wdata = 16'h0077;
        for (int k = 0; k < 4; k++) begin
            xfer(k[1], 1'b1, {23'h000800, k[0]}, CLASS_USER_DATA, 2'h0);
            chk(su === !k[0] && sl === k[0], "byte strobes");
            if (!k[1]) chk(sdo === 16'h7777, "byte mirror");
        end
    endtask

    task automatic sc_classes;
        logic [2:0] t[5] = '{CLASS_USER_DATA, CLASS_USER_PROG, CLASS_SUPV_DATA,
            CLASS_SUPV_PROG, CLASS_IRQ_ACK};
        irq_n = 3'h1;
        for (int j = 0; j < 5; j++) begin
            xfer(1'b1, 1'b0, 24'h00000A, t[j], 2'h0);
            chk(scls === t[j], "cycle class");
            if (j == 4) chk(sad === {IACK_ADDR_HIGH, 3'h5}, "iack address");
        end
        chk(irq_lvl === 3'h6, "irq level held");
        irq_n = 3'h7;
    endtask

    task automatic sc_fault;
        int i;
        xfer(1'b1, 1'b0, 24'h000300, CLASS_USER_DATA, 2'h2);
        chk(fault && !done, "fault with ack");
        xfer(1'b0, 1'b0, 24'h000300, CLASS_USER_DATA, 2'h1);
        chk(fault && !done, "fault alone");
        // Fault seen with external halt: no pulse, halt, then rerun once halt drops
        rd = 1'b1; byt = 1'b0; addr = 24'h000400; req = 1'b1;
        tick();
        req = 1'b0;
        for (i = 0; i < 10 && as_n; i++) tick();
        bound(i, 10);
        ext_halt = 1'b1;
        for (i = 0; i < 20 && !halted; i++) begin
            chk(!fault && !done, "pulse during retry");
            tick();
        end
        bound(i, 20);
        mode = 2'h0;
        ext_halt = 1'b0;
        for (i = 0; i < 40 && !done; i++) tick();
        bound(i, 40);
        chk(done && !fault && rdata === (addr[16:1] ^ 16'hC3A5), "retry after halt");
    endtask

    task automatic sc_slow;
        xfer(1'b1, 1'b0, 24'h000200, CLASS_USER_DATA, 2'h3);
        chk(done && sv, "slow read");
        chk(rdata === (addr[16:1] ^ 16'hC3A5), "slow data");
        xfer(1'b1, 1'b0, 24'h00000C, CLASS_IRQ_ACK, 2'h3);
        chk(autovec === 1'b1, "autovector");
    endtask

    task automatic sc_arb;
        int i;
        irq_n = 3'h2;
        mreq_n = 1'b0;
        for (i = 0; i < 10 && grant_n; i++) tick();
        bound(i, 10);
        chk(grant_n === 1'b0 && as_n === 1'b1 && ack_n, "grant");
        gt_n = 1'b0;
        mreq_n = 1'b1;
        tick(3);
        chk(!addr_oe && !ctrl_oe && !data_oe && grant_n, "float on grant");
        chk(irq_lvl === 3'h5, "irq level");
        gt_n = 1'b1;
        irq_n = 3'h7;
        tick(2);
    endtask

    task automatic sc_halt;
        int i;
        ext_halt = 1'b1;
        for (i = 0; i < 10 && !halted; i++) tick();
        bound(i, 10);
        chk(halted === 1'b1 && !addr_oe && ctrl_oe, "halt float");
        ext_rst = 1'b1;
        for (i = 0; i < 10 && !sys_init; i++) tick();
        bound(i, 10);
        chk(sys_init === 1'b1, "system init");
        ext_halt = 1'b0;
        ext_rst = 1'b0;
        tick(4);
        stopped = 1'b1;
        tick(2);
        chk(hl_oe === 1'b1, "halt drive");
        stopped = 1'b0;
        tick(2);
        rst_ext = 1'b1;
        tick();
        rst_ext = 1'b0;
        tick();
        chk(rl_oe === 1'b1, "reset drive");
        tick(RST_CYC + 2);
        chk(rl_oe === 1'b0, "reset drive end");
    endtask

    initial begin
        tick(16);
        sys_rst = 1'b0;
        tick();
        sc_word();
        sc_bytes();
        sc_classes();
        sc_fault();
        sc_slow();
        sc_arb();
        sc_halt();
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick();
        sc_word();
        summarize();
    end
endmodule

bind cabi_top cabi_top_props cabi_top_props_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .ADDR_STROBE_N(ADDR_STROBE_N), .CYCLE_CLASS(CYCLE_CLASS), .DATA_OE(DATA_OE),
    .DATA_OUT(DATA_OUT), .DIR_READ(DIR_READ), .UPPER_LANE_STROBE_N(UPPER_LANE_STROBE_N),
    .LOWER_LANE_STROBE_N(LOWER_LANE_STROBE_N), .ENABLE_CLK(ENABLE_CLK),
    .SLOW_ADDR_VALID_N(SLOW_ADDR_VALID_N), .BUS_FAULT_IN_N(BUS_FAULT_IN_N),
    .HALT_LINE_IN_N(HALT_LINE_IN_N), .CORE_FAULT(CORE_FAULT), .GRANT_TAKEN_N(GRANT_TAKEN_N),
    .ADDR_OE(ADDR_OE), .CTRL_OE(CTRL_OE), .CORE_HALTED(CORE_HALTED), .ADDR_OUT(ADDR_OUT));
